// ---- core/sdsu_addsub.sv ----
// Adder/subtractor for the divide datapath, with carry out.
// Assumes purely combinational use inside the unit.
`timescale 1ns/100ps
`default_nettype none

module sdsu_addsub #(
  parameter int W = 16
) (
  // Operands
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  // Control: high subtracts b from a
  input wire logic sub_i,
  // Results
  output logic [W-1:0] sum_o,
  output logic cout_o
);

  // Inverted operand when subtracting
  logic [W-1:0] b_eff;
  // Full sum including the carry bit
  logic [W:0] total;

  // ==========================================================
  // Two's complement add: a + ~b + 1 for subtract
  always_comb
  begin
    b_eff = sub_i ? ~b_i : b_i;
    total = {1'b0, a_i} + {1'b0, b_eff} + {{W{1'b0}}, sub_i};
  end

  // Carry out high means no borrow on a subtract
  assign sum_o = total[W-1:0];
  assign cout_o = total[W];

endmodule

`default_nettype wire

// ---- core/sdsu_core.sv ----
// Signed divide and shift unit: non-restoring 32/16 divide and
// single and double word arithmetic shifts, on a local register bank
// reached over classic Wishbone.
// Assumes one clock; the processor reads condition codes from CC_O.
//
// Contract
// - Divisor in B, dividend magnitude in accumulators
// - Zero divisor aborts, sets Z V C
// - First step tests overflow, then fifteen more
// - Shift dividend left before each step
// - Subtract when divisor sign differs quotient bit
// - Otherwise add, carry enters low bit
// - Carry out means no underflow
// - Final zero bit corrects remainder
// - Wrong-signed remainder is complemented
// - Negative dividend gives negative remainder
// - Quotient top bit set aborts overflow
// - Same signs store quotient unchanged
// - Differing signs negate; most negative errs
// - Single shift operand into accumulator, B cleared
// - Low six count bits give direction
// - Zero count sets codes immediately
// - Left shift stores, counter increments
// - Right shift counter decrements
// - Double shift on 32 bits
// - Even register high, odd register low
// - Double shift codes as single shift
//
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "sdsu_params.svh"

module sdsu_core #(
  parameter int ADR_W = 8
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  // Wishbone slave request
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  // Wishbone slave answer
  output logic WB_ACK_O,
  output logic [31:0] WB_DAT_O,
  // Processor status side
  output sdsu_pkg::sdsu_cc_t CC_O,
  output logic CC_STB_O,
  output logic EXT_NEG_O,
  output logic BUSY_O
);

  // Reset synchroniser stages
  logic [1:0] rsync_q;
  // Synchronised active-low reset
  logic rst_n;
  // Registered and next state
  sdsu_pkg::sdsu_core_t s_q;
  sdsu_pkg::sdsu_core_t s_d;
  // Bus request taken this cycle
  logic take;
  // Decoded register index
  logic [3:0] idx;
  // Register index from the command data
  logic [2:0] wsf;
  logic [2:0] wodd;
  // Odd partner of the current source register
  logic [2:0] sf_odd;
  // Adder connections
  logic [15:0] alu_a;
  logic [15:0] alu_sum;
  logic alu_sub;
  logic alu_cout;

  // ==========================================================
  // Address decode, shared by the read and write paths
  function automatic logic [3:0] decode(input logic [ADR_W-1:0] adr);
    logic [ADR_W-1:0] a;
    a = {adr[ADR_W-1:2], 2'h0};
    if (a < ADR_W'(`SDSU_OFF_OPND))
      decode = {1'b0, a[4:2]};
    else if (a == ADR_W'(`SDSU_OFF_OPND))
      decode = `SDSU_IDX_OPND;
    else if (a == ADR_W'(`SDSU_OFF_CMD))
      decode = `SDSU_IDX_CMD;
    else if (a == ADR_W'(`SDSU_OFF_STAT))
      decode = `SDSU_IDX_STAT;
    else
      decode = `SDSU_IDX_NONE;
  endfunction

  // ==========================================================
  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = old;
    if (be[0])
      merge16[7:0] = wd[7:0];
    if (be[1])
      merge16[15:8] = wd[15:8];
  endfunction

  // ==========================================================
  // Reset release through two flip-flops
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      rsync_q <= 2'h0;
    else
      rsync_q <= {rsync_q[0], 1'b1};
  end

  assign rst_n = rsync_q[1];

  // ==========================================================
  // Decode helpers
  assign take = WB_CYC_I & WB_STB_I & ~s_q.ack;
  assign idx = decode(WB_ADR_I);
  assign wsf = WB_DAT_I[`SDSU_CMD_SF_LSB +: 3];
  assign wodd = {wsf[2:1], 1'b1};
  assign sf_odd = {s_q.sf[2:1], 1'b1};

  // ==========================================================
  // Adder inputs: shifted pair while stepping, plain remainder at fix-up
  // shift before step
  assign alu_a = (s_q.state == sdsu_pkg::S_DIV_FIX) ? s_q.hacc : {s_q.hacc[14:0], s_q.lsr[15]};
  // fix-up adds positive, subtracts negative divisor
  assign alu_sub = (s_q.state == sdsu_pkg::S_DIV_FIX) ? s_q.bdiv[15] : (s_q.bdiv[15] ^ s_q.qbit);

  // Shared adder/subtractor
  sdsu_addsub #(
    .W(16)
  ) u_alu (
    .a_i(alu_a),
    .b_i(s_q.bdiv),
    .sub_i(alu_sub),
    .sum_o(alu_sum),
    .cout_o(alu_cout)
  );

  // ==========================================================
  // Next-state logic: bus slave and operation sequencer
  always_comb
  begin
    logic [31:0] dvd;
    logic [31:0] mag;
    logic [15:0] rem;
    logic [15:0] quo;
    logic [`SDSU_CNT_W-1:0] cext;
    dvd = {s_q.gpr[wsf], s_q.gpr[wodd]};
    mag = dvd[31] ? (32'h0 - dvd) : dvd;
    rem = s_q.qbit ? s_q.hacc : alu_sum;
    quo = s_q.qneg ? (16'h0 - s_q.lsr) : s_q.lsr;
    cext = {s_q.opnd[5], s_q.opnd[5:0]};
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.cc_stb = 1'b0;

    // Bus access: answer one cycle after the request
    if (take)
    begin
      s_d.ack = 1'b1;
      // Read data captured once; unmapped reads return zero
      if (idx < `SDSU_IDX_OPND)
        s_d.dat = {16'h0, s_q.gpr[idx[2:0]]};
      else if (idx == `SDSU_IDX_OPND)
        s_d.dat = {16'h0, s_q.opnd};
      else if (idx == `SDSU_IDX_CMD)
        s_d.dat = {27'h0, s_q.sf, s_q.op};
      else if (idx == `SDSU_IDX_STAT)
        s_d.dat = {25'h0, s_q.ext_neg, s_q.cc, s_q.done, s_q.busy};
      else
        s_d.dat = 32'h0;
      // Writes only while idle, so the sequencer owns the bank when busy
      if (WB_WE_I && !s_q.busy)
      begin
        if (idx < `SDSU_IDX_OPND)
          s_d.gpr[idx[2:0]] = merge16(s_q.gpr[idx[2:0]], WB_DAT_I, WB_SEL_I);
        else if (idx == `SDSU_IDX_OPND)
          s_d.opnd = merge16(s_q.opnd, WB_DAT_I, WB_SEL_I);
        else if (idx == `SDSU_IDX_CMD && WB_SEL_I[0] &&
                 WB_DAT_I[`SDSU_CMD_OP_LSB +: 2] != `SDSU_OP_NONE)
        begin
          // Launch: clear last result and flags
          s_d.op = WB_DAT_I[`SDSU_CMD_OP_LSB +: 2];
          s_d.sf = wsf;
          s_d.busy = 1'b1;
          s_d.done = 1'b0;
          s_d.cc = '0;
          if (WB_DAT_I[`SDSU_CMD_OP_LSB +: 2] == `SDSU_OP_DIV)
          begin
            s_d.hacc = mag[31:16];
            s_d.lsr = mag[15:0];
            s_d.bdiv = s_q.opnd;
            s_d.ext_neg = dvd[31];
            s_d.qneg = dvd[31] ^ s_q.opnd[15];
            // First step sees no prior underflow
            s_d.qbit = 1'b1;
            s_d.cnt = `SDSU_DIV_STEPS;
            s_d.state = sdsu_pkg::S_DIV_CHK;
          end
          else
          begin
            // even register high, odd register low
            s_d.hacc = s_q.gpr[wsf];
            s_d.lsr = (WB_DAT_I[`SDSU_CMD_OP_LSB +: 2] == `SDSU_OP_SHIFT_PAIR) ? s_q.gpr[wodd] : 16'h0;
            s_d.bdiv = 16'h0;
            s_d.ext_neg = 1'b0;
            // six-bit signed count, negated so both loops end at zero
            // count from low six operand bits
            s_d.cnt = `SDSU_CNT_W'(0) - cext;
            s_d.state = sdsu_pkg::S_SH_LOOP;
          end
        end
      end
    end

    // Operation sequencer
    case (s_q.state)
      sdsu_pkg::S_IDLE:
      begin
        // Wait for a command write
      end
      sdsu_pkg::S_DIV_CHK:
      begin
        if (s_q.bdiv == 16'h0)
        begin
          s_d.cc = '{n: 1'b0, z: 1'b1, v: 1'b1, c: 1'b1};
          s_d.state = sdsu_pkg::S_FINISH;
        end
        // Most negative double word cannot be made positive
        else if (s_q.ext_neg && {s_q.hacc, s_q.lsr} == `SDSU_MOST_NEG32)
        begin
          s_d.cc.v = 1'b1;
          s_d.state = sdsu_pkg::S_FINISH;
        end
        else
          s_d.state = sdsu_pkg::S_DIV_STEP;
      end
      sdsu_pkg::S_DIV_STEP:
      begin
        // pair shifts left, top bit dropped
        // carry out is the quotient bit
        s_d.hacc = alu_sum;
        s_d.lsr = {s_q.lsr[14:0], alu_cout};
        s_d.qbit = alu_cout;
        s_d.cnt = s_q.cnt - `SDSU_CNT_W'(1);
        if (s_q.cnt == `SDSU_DIV_STEPS && alu_cout)
        begin
          s_d.cc.v = 1'b1;
          s_d.state = sdsu_pkg::S_FINISH;
        end
        else if (s_q.cnt == `SDSU_CNT_W'(1))
          s_d.state = sdsu_pkg::S_DIV_FIX;
      end
      sdsu_pkg::S_DIV_FIX:
      begin
        // quotient top bit must be clear
        // negated quotient at most negative is an error
        if (s_q.lsr[15] || (s_q.qneg && quo == `SDSU_MOST_NEG16))
          s_d.cc.v = 1'b1;
        else
        begin
          // quotient stored, negated only when signs differed
          s_d.gpr[s_q.sf] = quo;
          // corrected remainder when last bit is zero
          s_d.gpr[sf_odd] = s_q.ext_neg ? (16'h0 - rem) : rem;
          s_d.cc.n = quo[15];
          s_d.cc.z = (quo == 16'h0);
        end
        s_d.state = sdsu_pkg::S_FINISH;
      end
      sdsu_pkg::S_SH_LOOP:
      begin
        // count exhausted or zero, codes set now
        // double shift codes as single shift
        // N and Z from the result
        if (s_q.cnt == `SDSU_CNT_W'(0))
        begin
          s_d.cc.n = s_q.hacc[15];
          if (s_q.op == `SDSU_OP_SHIFT_PAIR)
          begin
            s_d.cc.z = ({s_q.hacc, s_q.lsr} == 32'h0);
            // low answer to the odd register at the end
            s_d.gpr[sf_odd] = s_q.lsr;
          end
          else
            s_d.cc.z = (s_q.hacc == 16'h0);
          s_d.state = sdsu_pkg::S_FINISH;
        end
        else if (s_q.cnt[`SDSU_CNT_W-1])
        begin
          // carry is bit out, overflow on sign change
          s_d.cc.c = s_q.hacc[15];
          if (s_q.hacc[15] ^ s_q.hacc[14])
            s_d.cc.v = 1'b1;
          // 32-bit pair for the double shift
          if (s_q.op == `SDSU_OP_SHIFT_PAIR)
            {s_d.hacc, s_d.lsr} = {s_q.hacc[14:0], s_q.lsr, 1'b0};
          else
            s_d.hacc = {s_q.hacc[14:0], 1'b0};
          s_d.gpr[s_q.sf] = s_d.hacc;
          s_d.cnt = s_q.cnt + `SDSU_CNT_W'(1);
        end
        else
        begin
          // Arithmetic right shift never changes the sign
          if (s_q.op == `SDSU_OP_SHIFT_PAIR)
          begin
            s_d.cc.c = s_q.lsr[0];
            {s_d.hacc, s_d.lsr} = {s_q.hacc[15], s_q.hacc, s_q.lsr[15:1]};
          end
          else
          begin
            s_d.cc.c = s_q.hacc[0];
            s_d.hacc = {s_q.hacc[15], s_q.hacc[15:1]};
          end
          // high answer stored during the loop
          s_d.gpr[s_q.sf] = s_d.hacc;
          s_d.cnt = s_q.cnt - `SDSU_CNT_W'(1);
        end
      end
      sdsu_pkg::S_FINISH:
      begin
        // Codes transferred to the processor status as one strobe
        s_d.cc_out = s_q.cc;
        s_d.cc_stb = 1'b1;
        s_d.done = 1'b1;
        s_d.busy = 1'b0;
        s_d.state = sdsu_pkg::S_IDLE;
      end
      default:
        s_d.state = sdsu_pkg::S_IDLE;
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ==========================================================
  // Outputs, all straight from the state register
  assign WB_ACK_O = s_q.ack;
  assign WB_DAT_O = s_q.dat;
  assign CC_O = s_q.cc_out;
  assign CC_STB_O = s_q.cc_stb;
  assign EXT_NEG_O = s_q.ext_neg;
  assign BUSY_O = s_q.busy;

endmodule

`default_nettype wire

// ---- core/sdsu_params.svh ----
// Constants for the signed divide and shift unit: register map,
// command fields, operation codes and sequence counts.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`ifndef SDSU_PARAMS_SVH
`define SDSU_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define SDSU_OFF_GPR0 8'h00
`define SDSU_OFF_OPND 8'h20
`define SDSU_OFF_CMD 8'h24
`define SDSU_OFF_STAT 8'h28

// ==========================================================
// Internal register indices after address decode
`define SDSU_IDX_OPND 4'h8
`define SDSU_IDX_CMD 4'h9
`define SDSU_IDX_STAT 4'hA
`define SDSU_IDX_NONE 4'hF

// ==========================================================
// Command register fields and operation codes
`define SDSU_CMD_OP_LSB 0
`define SDSU_CMD_SF_LSB 2
`define SDSU_OP_NONE 2'h0
`define SDSU_OP_DIV 2'h1
`define SDSU_OP_SHIFT 2'h2
`define SDSU_OP_SHIFT_PAIR 2'h3

// ==========================================================
// Arithmetic constants
`define SDSU_DIV_STEPS 7'h10
`define SDSU_CNT_W 7
`define SDSU_MOST_NEG16 16'h8000
`define SDSU_MOST_NEG32 32'h8000_0000

`endif

// ---- core/sdsu_pkg.sv ----
// Types shared by the signed divide and shift unit.
// Assumes sdsu_params.svh is on the include path.
`include "sdsu_params.svh"

package sdsu_pkg;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE,
    S_DIV_CHK,
    S_DIV_STEP,
    S_DIV_FIX,
    S_SH_LOOP,
    S_FINISH
  } sdsu_state_t;

  // ==========================================================
  // Condition codes handed to the processor status
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } sdsu_cc_t;

  // ==========================================================
  // Whole state of the unit
  typedef struct packed {
    sdsu_state_t state;
    logic busy;
    logic [1:0] op;
    logic [2:0] sf;
    logic [7:0][15:0] gpr;
    logic [15:0] opnd;
    logic [15:0] hacc;
    logic [15:0] lsr;
    logic [15:0] bdiv;
    logic [`SDSU_CNT_W-1:0] cnt;
    logic qbit;
    logic qneg;
    logic ext_neg;
    sdsu_cc_t cc;
    logic done;
    logic ack;
    logic [31:0] dat;
    sdsu_cc_t cc_out;
    logic cc_stb;
  } sdsu_core_t;

endpackage

// ---- verif/sdsu_core_chk.sv ----
// Concurrent checks on the top ports of the divide and shift unit.
// Assumes one clock and the command offset of the register map.
`timescale 1ns/100ps
`default_nettype none
`include "sdsu_params.svh"

module sdsu_core_chk #(
  parameter int ADR_W = 8
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  // Bus request
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  // Bus answer
  input wire logic WB_ACK_O,
  input wire logic [31:0] WB_DAT_O,
  // Status side
  input wire sdsu_pkg::sdsu_cc_t CC_O,
  input wire logic CC_STB_O,
  input wire logic EXT_NEG_O,
  input wire logic BUSY_O
);
  // ==========
  // Helper logic
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  logic go; // Command write taken while idle
  logic go_div; // That command is a divide
  logic div_q; // Last launch was a divide
  assign go = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && !BUSY_O && WB_SEL_I[0]
    && {WB_ADR_I[7:2], 2'h0} == `SDSU_OFF_CMD && WB_DAT_I[1:0] != 2'h0;
  assign go_div = go && WB_DAT_I[1:0] == `SDSU_OP_DIV;
  // Remember the kind of the running operation
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      div_q <= 1'b0;
    else if (go)
      div_q <= go_div;
  end
  // ==========
  // Assertions
  ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  ack_latency_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not acked next cycle");
  div_done_a: assert property (go_div |-> ##[3:20] CC_STB_O)
    else $error("divide did not finish in time");
  shift_done_a: assert property (go && !go_div |-> ##[3:35] CC_STB_O)
    else $error("shift did not finish in time");
  busy_hold_a: assert property (go |=> BUSY_O until CC_STB_O)
    else $error("busy dropped before finish");
  cc_hold_a: assert property ($changed(CC_O) |-> CC_STB_O)
    else $error("codes changed without strobe");
  div_err_codes_a: assert property (CC_STB_O && div_q && CC_O.c |-> CC_O.z && CC_O.v && !CC_O.n)
    else $error("zero divisor codes wrong");
  div_ok_codes_a: assert property (CC_STB_O && div_q && !CC_O.v |-> !CC_O.c)
    else $error("carry set on good divide");
  shift_ext_a: assert property (CC_STB_O && !div_q |-> !EXT_NEG_O)
    else $error("negative dividend flag after shift");
endmodule

bind sdsu_core sdsu_core_chk #(.ADR_W(ADR_W)) u_sdsu_core_chk (
  .CORE_CLK_I(CORE_CLK_I),
  .RSTN_I(RSTN_I),
  .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I),
  .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I),
  .WB_ACK_O(WB_ACK_O),
  .WB_DAT_O(WB_DAT_O),
  .CC_O(CC_O),
  .CC_STB_O(CC_STB_O),
  .EXT_NEG_O(EXT_NEG_O),
  .BUSY_O(BUSY_O)
);
`default_nettype wire

// ---- verif/sdsu_core_tb.sv ----
// Self-checking bench for the divide and shift unit.
// Assumes the register map of sdsu_params.svh.
`timescale 1ns/100ps
`default_nettype none
`include "sdsu_params.svh"
`define CHK(nm, e, a) begin comparisons++; if ((e) !== (a)) begin fail_count++; $display("ERROR %s exp %h got %h", nm, e, a); end end

module sdsu_core_tb;
  logic clk;
  logic rstn;
  logic cyc, stb, we, ack, cc_stb, ext_neg, busy;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r, exp_r;
  sdsu_pkg::sdsu_cc_t cc, psw;
  logic [31:0] rdq[$]; // Expected read data
  logic [3:0] ccq[$]; // Expected codes
  logic [3:0] exp_c, last_cc;
  logic [4:0] lastcmd; // Last accepted command
  int fail_count, comparisons;
  int cnts[8] = '{0, 1, 5, 31, 2, -1, -16, -32};

  sdsu_core u_sdsu_core (.CORE_CLK_I(clk), .RSTN_I(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_ACK_O(ack),
    .WB_DAT_O(dat_r), .CC_O(cc), .CC_STB_O(cc_stb), .EXT_NEG_O(ext_neg), .BUSY_O(busy));
  sdsu_psw_model u_sdsu_psw_model (.clk_i(clk), .rstn_i(rstn), .cc_stb_i(cc_stb), .cc_i(cc), .psw_o(psw));

  // ==========
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Monitor takes the oldest note per result
  always @(posedge clk)
  begin
    if (ack && !we)
    begin
      exp_r = rdq.size() ? rdq.pop_front() : 'x;
      `CHK("rdata", exp_r, dat_r)
    end
    if (cc_stb)
    begin
      exp_c = ccq.size() ? ccq.pop_front() : 'x;
      `CHK("cc", exp_c, cc)
    end
  end

  // ==========
  // Bus cycles
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
    input logic [15:0] e);
    int t;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_w <= {16'($urandom), d};
    if (!w) rdq.push_back({16'h0, e});
    t = 0;
    do @(posedge clk); while (ack !== 1'b1 && ++t < 99);
    if (ack !== 1'b1) fail_count++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wb(1'b1, a, d, 4'hF, 16'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    wb(1'b0, a, 16'h0, 4'hF, e);
  endtask

  function automatic logic [7:0] ga(input logic [2:0] s);
    return {3'h0, s, 2'h0};
  endfunction

  // Start an operation and wait until idle
  task automatic go(input logic [2:0] sf, input logic [1:0] op, input logic [15:0] poke);
    int t;
    ccq.push_back(last_cc);
    lastcmd = {sf, op};
    wr(`SDSU_OFF_CMD, {11'h0, sf, op});
    if (poke != 16'h0) wr(`SDSU_OFF_OPND, poke);
    t = 0;
    do @(posedge clk); while (busy !== 1'b0 && ++t < 99);
    if (busy !== 1'b0) fail_count++;
    @(posedge clk);
    `CHK("psw", last_cc, psw)
  endtask

  // ==========
  // Divide: truncating reference, sign of remainder follows dividend
  task automatic div(input logic [31:0] x, input logic [15:0] y, input logic [2:0] sf);
    int q, r;
    logic ok;
    logic [31:0] res;
    q = y == 16'h0 ? 0 : $signed(x) / $signed(y);
    r = y == 16'h0 ? 0 : $signed(x) % $signed(y);
    ok = y != 16'h0 && x != 32'h8000_0000 && q < 32768 && q > -32768;
    last_cc = y == 16'h0 ? 4'h7 : !ok ? 4'h2 : {q < 0, q == 0, 2'h0};
    res = ok ? {q[15:0], r[15:0]} : x;
    wr(ga(sf), x[31:16]);
    wr(ga(sf | 3'h1), x[15:0]);
    wr(`SDSU_OFF_OPND, y);
    go(sf, `SDSU_OP_DIV, 16'h0);
    `CHK("ext_neg", x[31], ext_neg)
    rd(ga(sf), res[31:16]);
    rd(ga(sf | 3'h1), res[15:0]);
    if (ok) rd(`SDSU_OFF_STAT, {9'h0, x[31], last_cc, 2'h2});
  endtask

  // Shift reference, one bit per pass
  function automatic logic [35:0] ref_sh(input logic [31:0] v, input int n, input logic dbl);
    logic c, vf;
    logic [31:0] r;
    c = 1'b0;
    vf = 1'b0;
    r = v;
    for (int i = 0; i < (n < 0 ? -n : n); i++)
    begin
      c = n > 0 ? r[31] : (dbl ? r[0] : r[16]);
      r = n > 0 ? {r[30:0], 1'b0} : {r[31], r[31:1]};
      vf |= n > 0 && (r[31] ^ c);
    end
    if (!dbl) r[15:0] = 16'h0;
    return {r[31], r == 32'h0, vf, c, r};
  endfunction

  task automatic sh(input logic dbl, input logic [31:0] v, input int n, input logic [2:0] sf);
    logic [35:0] e;
    logic [15:0] c;
    e = ref_sh(dbl ? v : {v[31:16], 16'h0}, n, dbl);
    c = {10'($urandom), 6'(n)};
    last_cc = e[35:32];
    wr(ga(sf), v[31:16]);
    if (dbl) wr(ga(sf | 3'h1), v[15:0]);
    wr(`SDSU_OFF_OPND, c);
    go(sf, dbl ? `SDSU_OP_SHIFT_PAIR : `SDSU_OP_SHIFT, (n > 1 || n < -1) ? ~c : 16'h0);
    `CHK("ext_neg", 1'b0, ext_neg)
    rd(ga(sf), e[31:16]);
    if (dbl) rd(ga(sf | 3'h1), e[15:0]);
    rd(`SDSU_OFF_OPND, c);
    rd(`SDSU_OFF_STAT, {9'h0, 1'b0, last_cc, 2'h2});
  endtask

  task wrap_up;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog cuts a hang short
  initial
  begin
    #2000000;
    fail_count++;
    wrap_up;
  end

  // ==========
  // Main sequence
  initial
  begin
    int a, b, x;
    void'($urandom(94));
    {rstn, cyc, stb, we, adr, sel, dat_w, last_cc, lastcmd} = '0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 11; i++) rd(8'(i * 4), 16'h0);
    wr(8'h30, 16'h5A5A);
    rd(8'h30, 16'h0);
    wb(1'b1, ga(0), 16'hABCD, 4'h2, 16'h0);
    rd(ga(0), 16'hAB00);
    div(32'h0000_0064, 16'h0007, 3'h0);
    div(32'hFFFF_FF9C, 16'h0007, 3'h2);
    div(32'h0000_0064, 16'hFFF9, 3'h4);
    div(32'hFFFF_FF9C, 16'hFFF9, 3'h6);
    div(32'h1234_5678, 16'h0000, 3'h0);
    div(32'h8000_0000, 16'h0001, 3'h2);
    div(32'h0001_0000, 16'h0001, 3'h4);
    div(32'h0000_8000, 16'h0001, 3'h6);
    repeat (20)
    begin
      a = 1 + $urandom % 16383;
      b = $urandom % 32767;
      x = b * a + $urandom % a;
      if ($urandom % 2) x = -x;
      if ($urandom % 2) a = -a;
      div(32'(x), 16'(a), {2'($urandom), 1'b0});
    end
    foreach (cnts[i])
    begin
      sh(1'b0, $urandom, cnts[i], 3'($urandom));
      sh(1'b1, $urandom, cnts[i], {2'($urandom), 1'b0});
    end
    wb(1'b1, `SDSU_OFF_CMD, 16'h0009, 4'hE, 16'h0);
    rd(`SDSU_OFF_CMD, {11'h0, lastcmd});
    `CHK("busy", 1'b0, busy)
    wrap_up;
  end
endmodule
`default_nettype wire

// ---- verif/sdsu_psw_model.sv ----
// Host processor status register fed by the unit's finish strobe.
// Assumes codes are valid in the strobe cycle.
`timescale 1ns/100ps
`default_nettype none

module sdsu_psw_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Codes from the unit
  input wire logic cc_stb_i,
  input wire sdsu_pkg::sdsu_cc_t cc_i,
  // Status held by the host
  output sdsu_pkg::sdsu_cc_t psw_o
);
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      psw_o <= '0;
    else if (cc_stb_i)
      psw_o <= cc_i;
  end
endmodule
`default_nettype wire
